// ### shared/sw_host_pkg.sv
// Shared constants and types for the single-line bus master and its CRC unit
package sw_host_pkg;

  // ******************************************************************
  // Line timing, in microseconds
  // ******************************************************************
  localparam logic [9:0] RESET_LOW_US      = 10'h1E0; // 480
  localparam logic [9:0] RESET_LOW_MAX_US  = 10'h3C0; // 960, rise time included
  localparam logic [9:0] RESET_HIGH_US     = 10'h1E0; // 480
  localparam logic [9:0] PRESENCE_SMP_US   = 10'h046; // 70, inside presence low
  localparam logic [9:0] SLOT_US           = 10'h046; // 70
  localparam logic [9:0] RECOVERY_US       = 10'h005; // 5
  localparam logic [9:0] WRITE_ONE_LOW_US  = 10'h006; // 6
  localparam logic [9:0] WRITE_ZERO_LOW_US = 10'h03C; // 60
  localparam logic [9:0] READ_LOW_US       = 10'h002; // 2
  localparam logic [9:0] READ_SMP_US       = 10'h00E; // 14, last us of read_valid_window
  localparam logic [9:0] READ_VALID_US     = 10'h00F; // 15
  localparam logic [9:0] PROG_US           = 10'h1E0; // 480

  // ******************************************************************
  // CRC constants
  // ******************************************************************
  localparam logic [7:0]  CRC8_POLY_REFL   = 8'h8C;    // x^8+x^5+x^4+1, bit-reversed
  localparam logic [15:0] CRC16_POLY_REFL  = 16'hA001; // x^16+x^15+x^2+1, bit-reversed
  localparam logic [7:0]  CRC8_RESET       = 8'h00;
  localparam logic [15:0] CRC16_RESET      = 16'h0000;
  localparam logic [15:0] CRC16_RESIDUE    = 16'hB001; // After data plus inverted CRC

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [1:0] {OP_RESET, OP_WRITE, OP_READ, OP_PROG} op_t;
  typedef enum logic [2:0] {ST_IDLE, ST_RST_LOW, ST_RST_HIGH, ST_SLOT, ST_PROG} ctl_state_t;

endpackage

// ### shared/crc_if.sv
// Link between the bus master sequencer and its CRC unit
`timescale 1ns/1ns
interface crc_if;
  logic        clear;
  logic        load;
  logic [15:0] load_value;
  logic        shift;
  logic        shift_bit;
  logic [7:0]  crc8;
  logic [15:0] crc16;

  modport master (output clear, load, load_value, shift, shift_bit, input crc8, crc16);
  modport engine (input clear, load, load_value, shift, shift_bit, output crc8, crc16);
endinterface

// ### hw/crc_unit.sv
// Serial 8-bit and 16-bit CRC accumulators fed one line bit at a time
`timescale 1ns/1ns
module crc_unit (
  input  wire logic  i_clk_sys,
  input  wire logic  i_reset_n,
  crc_if.engine      bus
);

  typedef struct packed {
    logic [7:0]  crc8;
    logic [15:0] crc16;
  } crc_state_t;

  crc_state_t q;
  crc_state_t d;

  // ******************************************************************
  // Next value
  // ******************************************************************
  always_comb begin
    d = q;
    if (bus.clear) begin
      d.crc8  = sw_host_pkg::CRC8_RESET;
      d.crc16 = sw_host_pkg::CRC16_RESET;
    end else if (bus.load) begin
      d.crc16 = bus.load_value;
    end else if (bus.shift) begin
      // Reflected form: least significant bit enters first
      d.crc8 = {1'b0, q.crc8[7:1]} ^
               ((q.crc8[0] ^ bus.shift_bit) ? sw_host_pkg::CRC8_POLY_REFL : 8'h00);
      d.crc16 = {1'b0, q.crc16[15:1]} ^
                ((q.crc16[0] ^ bus.shift_bit) ? sw_host_pkg::CRC16_POLY_REFL : 16'h0000);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.crc8  = q.crc8;
  assign bus.crc16 = q.crc16;

endmodule

// ### hw/sw_master.sv
// Single-line bus master: reset, bit slots, program pulse and CRC checking
//
// Notes on behaviour
// - Master opens every read and write slot by pulling the line low.
// - Master keeps reset low plus rise time below 960 microseconds.
// - Master samples read data late, but within the 15 microsecond window.
// - Program pulse only after the current byte CRC checked correct.
// - Program pulse: drive 12 V for 480 microseconds, then back to idle.
// - No halt on CRC mismatch; the master decides to continue or retry.
// - Reset low at least 480 us; presence follows 15-60 us after release.
`timescale 1ns/1ns
module sw_master #(
  parameter int CLK_FREQ_HZ = 50_000_000
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset_n,
  input  wire logic        i_line,
  output logic             o_line_out,
  output logic             o_line_oe,
  output logic             o_prog_oe,
  input  wire logic        i_cmd_valid,
  input  wire logic [1:0]  i_cmd_op,
  input  wire logic        i_cmd_single,
  input  wire logic [7:0]  i_cmd_data,
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic [7:0]       o_rx_data,
  output logic             o_presence,
  output logic             o_prog_refused,
  input  wire logic        i_crc_clear,
  input  wire logic        i_crc_load,
  input  wire logic [15:0] i_crc_load_value,
  output logic [7:0]       o_crc8,
  output logic [15:0]      o_crc16,
  output logic             o_crc8_ok,
  output logic             o_crc16_ok
);

  localparam int CLKS_PER_US = CLK_FREQ_HZ / 1_000_000;
  localparam int DIV_W       = (CLKS_PER_US > 1) ? $clog2(CLKS_PER_US) : 1;
  localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLKS_PER_US - 1);

  // Cycle figures for the checks below
  localparam int RESET_MIN_CYC  = 480 * CLKS_PER_US;
  localparam int RESET_MAX_CYC  = 960 * CLKS_PER_US;
  localparam int PROG_CYC       = 480 * CLKS_PER_US;
  localparam int READ_VALID_CYC = 15 * CLKS_PER_US;
  localparam int WRITE0_CYC     = 60 * CLKS_PER_US;

  if (CLKS_PER_US < 1 || CLK_FREQ_HZ % 1_000_000 != 0) begin : g_bad_clk
    $error("CLK_FREQ_HZ must be a whole number of MHz");
  end

  typedef struct packed {
    sw_host_pkg::ctl_state_t st;
    logic [DIV_W-1:0]        div;
    logic [9:0]              us;
    logic [2:0]              idx;
    logic [7:0]              sh;
    logic                    rd;
    logic                    oe;
    logic                    prog;
    logic                    done;
    logic                    pres;
    logic                    refused;
    logic [7:0]              rx;
  } ctl_t;

  ctl_t q;
  ctl_t d;
  logic tick;
  logic slot_end;
  logic sample;
  logic [9:0] low_len;

  crc_if crc ();

  crc_unit u_crc (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .bus       (crc.engine)
  );

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb begin
    d         = q;
    d.done    = 1'b0;
    d.refused = 1'b0;
    tick      = (q.div == DIV_MAX);
    d.div     = tick ? '0 : q.div + DIV_W'(1);
    d.us      = tick ? q.us + 10'h001 : q.us;
    slot_end  = (q.st == sw_host_pkg::ST_SLOT) && tick &&
                (q.us == sw_host_pkg::SLOT_US + sw_host_pkg::RECOVERY_US - 10'h001);
    // Latest safe point: end of the 14th us after our own falling edge
    sample    = (q.st == sw_host_pkg::ST_SLOT) && q.rd && tick &&
                (q.us == sw_host_pkg::READ_SMP_US - 10'h001);
    case (q.st)
      sw_host_pkg::ST_IDLE: begin
        d.div = '0;
        d.us  = '0;
        if (i_cmd_valid) begin
          d.idx = i_cmd_single ? 3'h0 : 3'h7;
          case (sw_host_pkg::op_t'(i_cmd_op))
            sw_host_pkg::OP_RESET: begin
              d.st   = sw_host_pkg::ST_RST_LOW;
              d.pres = 1'b0;
            end
            sw_host_pkg::OP_WRITE: begin
              d.st = sw_host_pkg::ST_SLOT;
              d.rd = 1'b0;
              d.sh = i_cmd_data;
            end
            sw_host_pkg::OP_READ: begin
              d.st = sw_host_pkg::ST_SLOT;
              d.rd = 1'b1;
              d.sh = 8'h00;
            end
            default: begin
              // Programming an unchecked byte would burn bad data for good
              if (o_crc16_ok) begin
                d.st = sw_host_pkg::ST_PROG;
              end else begin
                d.refused = 1'b1;
                d.done    = 1'b1;
              end
            end
          endcase
        end
      end
      sw_host_pkg::ST_RST_LOW: begin
        if (tick && q.us == sw_host_pkg::RESET_LOW_US - 10'h001) begin
          d.st  = sw_host_pkg::ST_RST_HIGH;
          d.div = '0;
          d.us  = '0;
        end
      end
      sw_host_pkg::ST_RST_HIGH: begin
        if (tick && q.us == sw_host_pkg::PRESENCE_SMP_US - 10'h001) begin
          d.pres = ~i_line;
        end
        if (tick && q.us == sw_host_pkg::RESET_HIGH_US - 10'h001) begin
          d.st   = sw_host_pkg::ST_IDLE;
          d.done = 1'b1;
        end
      end
      sw_host_pkg::ST_SLOT: begin
        if (sample) begin
          d.sh = {i_line, q.sh[7:1]};
        end
        if (slot_end) begin
          d.div = '0;
          d.us  = '0;
          if (!q.rd) begin
            d.sh = {1'b0, q.sh[7:1]};
          end
          if (q.idx == 3'h0) begin
            d.st   = sw_host_pkg::ST_IDLE;
            d.done = 1'b1;
            d.rx   = q.sh;
          end else begin
            d.idx = q.idx - 3'h1;
          end
        end
      end
      sw_host_pkg::ST_PROG: begin
        if (tick && q.us == sw_host_pkg::PROG_US - 10'h001) begin
          d.st   = sw_host_pkg::ST_IDLE;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = sw_host_pkg::ST_IDLE;
      end
    endcase
    low_len = d.rd ? sw_host_pkg::READ_LOW_US :
              (d.sh[0] ? sw_host_pkg::WRITE_ONE_LOW_US : sw_host_pkg::WRITE_ZERO_LOW_US);
    d.oe   = (d.st == sw_host_pkg::ST_RST_LOW) ||
             ((d.st == sw_host_pkg::ST_SLOT) && (d.us < low_len));
    d.prog = (d.st == sw_host_pkg::ST_PROG);
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ******************************************************************
  // CRC feed and outputs
  // ******************************************************************
  // Each line bit, written or read, enters both generators as it completes
  assign crc.clear      = i_crc_clear;
  assign crc.load       = i_crc_load;
  assign crc.load_value = i_crc_load_value;
  assign crc.shift      = slot_end;
  assign crc.shift_bit  = q.rd ? q.sh[7] : q.sh[0];

  assign o_line_out     = 1'b0;
  assign o_line_oe      = q.oe;
  assign o_prog_oe      = q.prog;
  assign o_cmd_ready    = (q.st == sw_host_pkg::ST_IDLE);
  assign o_done         = q.done;
  assign o_rx_data      = q.rx;
  assign o_presence     = q.pres;
  assign o_prog_refused = q.refused;
  assign o_crc8         = crc.crc8;
  assign o_crc16        = crc.crc16;
  assign o_crc8_ok      = (crc.crc8 == sw_host_pkg::CRC8_RESET);
  assign o_crc16_ok     = (crc.crc16 == sw_host_pkg::CRC16_RESIDUE);

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [15:0] low_run;
  logic [15:0] prog_run;
  logic [15:0] slot_cyc;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_run  <= 16'h0000;
      prog_run <= 16'h0000;
      slot_cyc <= 16'h0000;
    end else begin
      low_run  <= q.oe ? low_run + 16'h0001 : 16'h0000;
      prog_run <= q.prog ? prog_run + 16'h0001 : 16'h0000;
      slot_cyc <= (q.st == sw_host_pkg::ST_SLOT && !slot_end) ? slot_cyc + 16'h0001 : 16'h0000;
    end
  end

  slot_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(q.oe) |-> q.us == 10'h000 &&
      (q.st == sw_host_pkg::ST_SLOT || q.st == sw_host_pkg::ST_RST_LOW))
    else $error("line pulled low outside a slot or reset start");

  reset_low_max_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    32'(low_run) < RESET_MAX_CYC)
    else $error("reset low too long");

  reset_low_min_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(q.oe) && q.st == sw_host_pkg::ST_RST_HIGH |-> 32'($past(low_run)) == RESET_MIN_CYC - 1)
    else $error("reset low length wrong");

  read_sample_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    sample |-> 32'(slot_cyc) < READ_VALID_CYC && 32'(slot_cyc) >= READ_VALID_CYC - CLKS_PER_US - 1)
    else $error("read sample outside late window");

  prog_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(q.prog) |-> $past(o_crc16_ok))
    else $error("program pulse without good CRC");

  prog_len_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(q.prog) |-> 32'($past(prog_run)) == PROG_CYC - 1 && o_done)
    else $error("program pulse length wrong");

  prog_excl_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    q.prog |-> !q.oe ##1 (q.prog || !q.oe))
    else $error("pulldown and programming drive overlap");

  write_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $fell(q.oe) && q.st == sw_host_pkg::ST_SLOT && !q.rd && !q.sh[0]
      |-> 32'($past(low_run)) == WRITE0_CYC - 1)
    else $error("write zero low time wrong");

  no_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_done && !o_prog_refused && !i_cmd_valid |=> o_cmd_ready)
    else $error("sequencer blocked after a transfer");

endmodule

// ### tb/sw_device_model.sv
// Behavioural stand-in for the addressable switch on the shared line
`timescale 1ns/1ns
module sw_device_model #(
  parameter int DELAY_NS   = 30000,
  parameter int PDH_NS     = 30000,
  parameter int PDL_NS     = 120000,
  parameter int RST_MIN_NS = 480000,
  parameter int POR_NS     = 5000000
) (
  input  wire logic i_line,
  input  wire logic i_read_en,
  input  wire logic i_tx_bit,
  output logic      o_pull_low,
  output logic      o_rx_bit,
  output int        o_presence_cnt
);
  time fall_t;

  initial begin
    o_pull_low     = 1'b0;
    o_rx_bit       = 1'b0;
    o_presence_cnt = 0;
    fall_t         = 0;
  end

  // Own pulls also fall the line, so they must not restart the delay
  always @(negedge i_line) begin
    fall_t = $time;
    if (!o_pull_low) begin
      if (i_read_en && !i_tx_bit) begin
        o_pull_low = 1'b1;
        #(DELAY_NS);
        o_pull_low = 1'b0;
      end else begin
        #(DELAY_NS);
        o_rx_bit = i_line;
      end
    end
  end

  always @(posedge i_line) begin
    // Line-powered part loses its state after an overlong low
    if ($time - fall_t > POR_NS) begin
      o_presence_cnt = 0;
    end
    if (($time - fall_t >= RST_MIN_NS) && !o_pull_low) begin
      #(PDH_NS);
      o_pull_low     = 1'b1;
      o_presence_cnt = o_presence_cnt + 1;
      #(PDL_NS);
      o_pull_low     = 1'b0;
    end
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the single-line bus master
`timescale 1ns/1ns
module testbench;
  logic        i_clk_sys    = 1'b0;
  logic        i_reset_n    = 1'b0;
  logic        cmd_valid    = 1'b0;
  logic [1:0]  cmd_op       = 2'h0;
  logic [7:0]  cmd_data     = 8'h00;
  logic        crc_clear    = 1'b0;
  logic        crc_load     = 1'b0;
  logic [15:0] crc_load_val = 16'h0000;
  logic        dev_read_en  = 1'b0;
  logic        dev_tx_bit   = 1'b1;
  logic        line_out;
  logic        line_oe;
  logic        prog_oe;
  logic        cmd_ready;
  logic        done;
  logic        presence;
  logic        refused;
  logic        crc8_ok;
  logic        crc16_ok;
  logic        dev_pull;
  logic        dev_rx_bit;
  logic [7:0]  rx_data;
  logic [7:0]  crc8;
  logic [15:0] crc16;
  logic [15:0] exp16        = 16'h0000;
  logic [7:0]  exp8         = 8'h00;
  logic        seen_refused = 1'b0;
  logic        overlap      = 1'b0;
  int          dev_pres_cnt;
  int          error_cnt    = 0;
  int          checks_done  = 0;
  int          oe_cnt       = 0;
  int          oe_run       = 0;
  int          pp_cnt       = 0;
  int          pp_run       = 0;
  wire         line         = (line_oe ? line_out : 1'b1) & ~dev_pull;

  always #10 i_clk_sys = ~i_clk_sys;

  sw_master u_dut (
    .i_clk_sys        (i_clk_sys),
    .i_reset_n        (i_reset_n),
    .i_line           (line),
    .o_line_out       (line_out),
    .o_line_oe        (line_oe),
    .o_prog_oe        (prog_oe),
    .i_cmd_valid      (cmd_valid),
    .i_cmd_op         (cmd_op),
    .i_cmd_single     (1'b1),
    .i_cmd_data       (cmd_data),
    .o_cmd_ready      (cmd_ready),
    .o_done           (done),
    .o_rx_data        (rx_data),
    .o_presence       (presence),
    .o_prog_refused   (refused),
    .i_crc_clear      (crc_clear),
    .i_crc_load       (crc_load),
    .i_crc_load_value (crc_load_val),
    .o_crc8           (crc8),
    .o_crc16          (crc16),
    .o_crc8_ok        (crc8_ok),
    .o_crc16_ok       (crc16_ok)
  );

  sw_device_model u_dev (
    .i_line         (line),
    .i_read_en      (dev_read_en),
    .i_tx_bit       (dev_tx_bit),
    .o_pull_low     (dev_pull),
    .o_rx_bit       (dev_rx_bit),
    .o_presence_cnt (dev_pres_cnt)
  );

  // ******************************************************************
  // Drive-length monitor
  // ******************************************************************
  always @(negedge i_clk_sys) begin
    if (line_oe) oe_cnt++;
    else if (oe_cnt != 0) begin
      oe_run = oe_cnt;
      oe_cnt = 0;
    end
    if (prog_oe) pp_cnt++;
    else if (pp_cnt != 0) begin
      pp_run = pp_cnt;
      pp_cnt = 0;
    end
    if (line_oe && prog_oe) overlap = 1'b1;
  end

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic b);
    crc16_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? 16'hA001 : 16'h0000);
  endfunction

  function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic b);
    crc8_step = (c >> 1) ^ (((c[0] ^ b) == 1'b1) ? 8'h8C : 8'h00);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Single command; refused pulse is caught in the done cycle
  task automatic run_cmd(input logic [1:0] op, input logic [7:0] data);
    int n;
    @(negedge i_clk_sys);
    chk("ready", cmd_ready, 1'b1);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_data  = data;
    @(negedge i_clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= 60000) begin
      error_cnt++;
      end_sim();
    end
    seen_refused = refused;
    @(negedge i_clk_sys);
  endtask

  task automatic pulse_crc(input logic clr, input logic ld, input logic [15:0] v);
    crc_clear    = clr;
    crc_load     = ld;
    crc_load_val = v;
    @(negedge i_clk_sys);
    crc_clear    = 1'b0;
    crc_load     = 1'b0;
    @(negedge i_clk_sys);
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    logic        is_rd;
    logic        b;
    logic [15:0] v;
    v = 16'($urandom(46730));
    repeat (4) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    chk("crc16_ok_rst", crc16_ok, 1'b0);
    chk("crc8_ok_rst", crc8_ok, 1'b1);
    run_cmd(sw_host_pkg::OP_RESET, 8'h00);
    chk("reset_low", oe_run, 24000);
    chk("presence", presence, 1'b1);
    chk("dev_presence", dev_pres_cnt, 1);
    // Plain cases first, then random slots
    for (int i = 0; i < 6; i++) begin
      is_rd = (i < 4) ? i[1] : 1'($urandom);
      b     = (i < 4) ? i[0] : 1'($urandom);
      dev_read_en = is_rd;
      dev_tx_bit  = b;
      run_cmd(is_rd ? sw_host_pkg::OP_READ : sw_host_pkg::OP_WRITE, {7'($urandom), b});
      if (is_rd) begin
        chk("rx_bit", rx_data[7], b);
        chk("read_low", oe_run, 100);
      end else begin
        chk("dev_sample", dev_rx_bit, b);
        chk("write_low", oe_run, b ? 300 : 3000);
      end
      exp16 = crc16_step(exp16, b);
      exp8  = crc8_step(exp8, b);
      chk("crc16", crc16, exp16);
      chk("crc8", crc8, exp8);
      chk("crc8_ok", crc8_ok, exp8 == 8'h00);
    end
    dev_read_en = 1'b0;
    pulse_crc(1'b0, 1'b1, v);
    chk("crc_load", crc16, v);
    pulse_crc(1'b1, 1'b1, v);
    chk("crc_clear16", crc16, 16'h0000);
    chk("crc_clear8", crc8, 8'h00);
    chk("crc16_bad", crc16_ok, 1'b0);
    run_cmd(sw_host_pkg::OP_PROG, 8'h00);
    chk("prog_refused", seen_refused, 1'b1);
    chk("prog_held", pp_run, 0);
    pulse_crc(1'b0, 1'b1, 16'hB001);
    chk("crc16_good", crc16_ok, 1'b1);
    run_cmd(sw_host_pkg::OP_PROG, 8'h00);
    chk("prog_taken", seen_refused, 1'b0);
    chk("prog_len", pp_run, 24000);
    chk("prog_alone", overlap, 1'b0);
    end_sim();
  end
endmodule
